/* rtl/phy_cfg_pkg.sv */
package phy_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
   localparam logic [7:0] OFS_CONFIG_TWO = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_COMMAND = 8'h14;
   // Reset values and writable masks
   localparam logic [31:0] CONFIG_ONE_RESET = 32'h0000_C403;
   localparam logic [31:0] CONFIG_ONE_MASK = 32'h007F_FFC7;
   localparam logic [31:0] CONFIG_TWO_RESET = 32'h00F1_2480;
   localparam logic [31:0] CONFIG_TWO_MASK = 32'h8FFF_FFFF;
   // Field positions, first configuration register
   localparam int DRIFT_LIMIT_LSB = 15;
   localparam int INIT_DEPTH_LSB = 13;
   localparam int LOWPASS_DEPTH_LSB = 11;
   localparam int LOWPASS_ENABLE_BIT = 10;
   localparam int MASTER_ENABLE_BIT = 9;
   localparam int IO_STANDARD_LSB = 7;
   localparam int SELECT_TYPE_BIT = 6;
   localparam int STEP_SIZE_BIT = 2;
   localparam int SOFT_LEVEL_BIT = 1;
   localparam int LANE_POWERDOWN_BIT = 0;
   // Field positions, second configuration register
   localparam int ADDR_POWERDOWN_BIT = 31;
   localparam int TRAIN_TIMER_LSB = 20;
   localparam int FIXED_LATENCY_BIT = 19;
   localparam int NO_BUBBLE_BIT = 18;
   localparam int REFRESH_LSB = 0;
   // Command and interrupt bits
   localparam int CMD_LEVEL_BIT = 0;
   localparam int CMD_CAL_BIT = 1;
   localparam int EV_DRIFT = 0;
   localparam int EV_CAL_DONE = 1;
   localparam int EV_LEVEL_DONE = 2;
   localparam int EV_TRAIN_DONE = 3;
   localparam int NUM_EVENTS = 4;
   // Widths
   localparam int LANES = 4;
   localparam int PERIOD_W = 10;
   // Write leveling step amounts
   localparam logic [9:0] STEP_COARSE = 10'h020;
   localparam logic [9:0] STEP_FINE = 10'h001;
   // Set-up margin in 45 degree units; hold is the rest of 180
   localparam logic [2:0] SETUP_90 = 3'h2;
   localparam logic [2:0] SETUP_135 = 3'h3;
   localparam logic [2:0] HALF_CYCLE_UNITS = 3'h4;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int LEVEL_CAPTURE_NS = 160;
   localparam int LEVEL_CAPTURE_CYCLES = (LEVEL_CAPTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Depth code 00..11 selects 2..16 samples, i.e. a shift of code+1
   function automatic logic [2:0] depth_shift(input logic [1:0] code);
      depth_shift = {1'b0, code} + 3'h1;
   endfunction : depth_shift
endpackage : phy_cfg_pkg

/* rtl/period_average.sv */
`timescale 1ns/10ps
`default_nettype none
module period_average
   import phy_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [1:0] depth_i,
   input wire logic sample_valid_i,
   input wire logic [PERIOD_W-1:0] sample_i,
   output logic done_o,
   output logic [PERIOD_W-1:0] mean_o
);
   logic [PERIOD_W+3:0] sum;
   logic [4:0] count;
   logic active;
   wire [2:0] shift = depth_shift(depth_i);
   wire [4:0] target = 5'h01 << shift;
   wire [PERIOD_W+3:0] next_sum = sum + {4'h0, sample_i};
   wire last = sample_valid_i && active && (count + 5'h01 == target);

   // Active from reset until the chosen number of samples is in
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sum <= '0;
         count <= '0;
         active <= 1'b1;
         done_o <= 1'b0;
         mean_o <= '0;
      end else if (start_i) begin
         sum <= '0;
         count <= '0;
         active <= 1'b1;
         done_o <= 1'b0;
      end else begin
         done_o <= last;
         if (sample_valid_i && active) begin
            sum <= next_sum;
            count <= count + 5'h01;
         end
         if (last) begin
            active <= 1'b0;
            mean_o <= PERIOD_W'(next_sum >> shift);
         end
      end
   end
endmodule : period_average
`default_nettype wire

/* rtl/drift_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module drift_monitor
   import phy_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [PERIOD_W-1:0] current_i,
   input wire logic [PERIOD_W-1:0] reference_i,
   input wire logic [7:0] limit_i,
   output logic drift_o
);
   // Distance in either direction, in delay select steps
   wire [PERIOD_W-1:0] distance = (current_i >= reference_i) ? current_i - reference_i : reference_i - current_i;
   // A zero limit never reports drift
   wire next_drift = (limit_i != 8'h00) && ({2'b00, limit_i} <= distance);

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         drift_o <= 1'b0;
      end else begin
         drift_o <= next_drift;
      end
   end
endmodule : drift_monitor
`default_nettype wire

/* rtl/phy_general_config.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// R01: Drift status rises when drift reaches limit; zero limit disables it; reset one.
// R02: Initial calibration averages 2, 4, 8 or 16 samples; code resets to 10.
// R03: Master delay measurements low-pass filtered over 2 to 16 samples; resets 00.
// R04: Low-pass enable bit turns filtering on; resets to one.
// R05: Master delay enable keeps measuring and filtering after calibration; resets zero.
// R06: Software writes one for DDR3, two for DDR3L; field resets zero.
// R07: Select type zero gives 90/90 margins; one gives 135 set-up, 45 hold.
// R08: Reserved bits five to three always read zero.
// R09: Each leveling step adds 32 increments, or one when step bit set.
// R10: Leveling trigger in software mode emits one DQS pulse, captures DQ response.
// R11: Power-down bit set powers down PLL and I/O of disabled lanes.
// R12: Second register resets timer 0xF, refresh 0x12480, bits 31,19,18 zero.
// R13: Training entry and exit wait the programmed number of clocks.
// R14: Fixed latency bit makes reads return with fixed latency.
// R15: Address power-down bit shuts off address and bank drivers.
// R16: Writes to reserved bits are ignored; they stay zero.
module phy_general_config
   import phy_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   input wire logic meas_valid_i,
   input wire logic [PERIOD_W-1:0] meas_period_i,
   input wire logic [LANES-1:0] lane_disabled_i,
   input wire logic [LANES-1:0] dq_response_i,
   input wire logic train_edge_i,
   output logic [PERIOD_W-1:0] calibrated_period_o,
   output logic delay_drift_status_o,
   output logic dqs_pulse_o,
   output logic [9:0] level_delay_o,
   output logic [2:0] level_setup_o,
   output logic [2:0] level_hold_o,
   output logic [1:0] io_standard_o,
   output logic [LANES-1:0] lane_powerdown_o,
   output logic address_driver_powerdown_o,
   output logic fixed_read_latency_o,
   output logic no_bubble_select_o,
   output logic [17:0] refresh_period_o,
   output logic train_wait_done_o
);
   typedef enum logic [2:0] {
      CAL_INIT = 3'b001,
      CAL_TRACK = 3'b010,
      CAL_HOLD = 3'b100
   } cal_state_type;
   typedef enum logic [2:0] {
      LV_IDLE = 3'b001,
      LV_PULSE = 3'b010,
      LV_WAIT = 3'b100
   } level_state_type;

   logic [31:0] phy_general_config_one;
   logic [31:0] phy_general_config_two;
   logic [NUM_EVENTS-1:0] irq_status;
   logic [NUM_EVENTS-1:0] irq_mask;
   cal_state_type cal_state;
   level_state_type level_state;
   logic [PERIOD_W-1:0] ref_period;
   logic [PERIOD_W-1:0] filt_period;
   logic [LANES-1:0] dq_meta;
   logic [LANES-1:0] dq_sync;
   logic [LANES-1:0] leveling_dq_status;
   logic [3:0] level_count;
   logic [7:0] train_count;
   logic train_busy;
   logic drift_prev;
   logic avg_done;
   logic [PERIOD_W-1:0] avg_mean;
   logic drift_now;

   // Field views of the configuration registers
   wire [7:0] drift_limit = phy_general_config_one[DRIFT_LIMIT_LSB +: 8];
   wire [1:0] initial_average_depth = phy_general_config_one[INIT_DEPTH_LSB +: 2];
   wire [1:0] lowpass_depth = phy_general_config_one[LOWPASS_DEPTH_LSB +: 2];
   wire lowpass_enable = phy_general_config_one[LOWPASS_ENABLE_BIT];
   wire master_delay_enable = phy_general_config_one[MASTER_ENABLE_BIT];
   wire leveling_select_type = phy_general_config_one[SELECT_TYPE_BIT];
   wire leveling_step_size = phy_general_config_one[STEP_SIZE_BIT];
   wire software_leveling = phy_general_config_one[SOFT_LEVEL_BIT];
   wire disabled_lane_powerdown = phy_general_config_one[LANE_POWERDOWN_BIT];
   wire [7:0] training_wait_timer = phy_general_config_two[TRAIN_TIMER_LSB +: 8];

   // Address decoding
   wire hit_one = (addr_i == OFS_CONFIG_ONE);
   wire hit_two = (addr_i == OFS_CONFIG_TWO);
   wire hit_status = (addr_i == OFS_STATUS);
   wire hit_irq = (addr_i == OFS_IRQ_STATUS);
   wire hit_mask = (addr_i == OFS_IRQ_MASK);
   wire hit_cmd = (addr_i == OFS_COMMAND);
   wire cmd_write = wr_i && hit_cmd;
   wire leveling_trigger = cmd_write && wdata_i[CMD_LEVEL_BIT];
   wire cal_trigger = cmd_write && wdata_i[CMD_CAL_BIT];

   // Status word: drift, capture, state, busy flags
   wire [31:0] status_word = {19'h0_0000, train_busy, ~level_state[0], cal_state, leveling_dq_status,
                              3'h0, drift_now};

   // Read mux; unmapped offsets answer zero
   wire [31:0] next_rdata = !rd_i ? 32'h0000_0000 :
                            hit_one ? phy_general_config_one :
                            hit_two ? phy_general_config_two :
                            hit_status ? status_word :
                            hit_irq ? {28'h000_0000, irq_status} :
                            hit_mask ? {28'h000_0000, irq_mask} :
                            32'h0000_0000;

   // R03 filter depth
   // First-order low-pass: move a 2^-k fraction of the error each sample
   function automatic logic [PERIOD_W-1:0] lowpass(input logic [PERIOD_W-1:0] y, input logic [PERIOD_W-1:0] x,
                                                   input logic [1:0] code);
      logic signed [PERIOD_W+1:0] err;
      err = $signed({2'b00, x}) - $signed({2'b00, y});
      lowpass = PERIOD_W'($signed({2'b00, y}) + (err >>> depth_shift(code)));
   endfunction : lowpass

   // R04 filter bypass
   wire [PERIOD_W-1:0] next_filt = lowpass_enable ? lowpass(filt_period, meas_period_i, lowpass_depth)
                                                  : meas_period_i;

   // R09 step amount
   wire [9:0] step_amount = leveling_step_size ? STEP_FINE : STEP_COARSE;

   // R07 margin encoding
   wire [2:0] next_setup = leveling_select_type ? SETUP_135 : SETUP_90;

   // Events raised this cycle
   wire drift_rise = drift_now && !drift_prev;
   wire level_capture = (level_state == LV_WAIT) && (level_count == 4'h0);
   wire train_done = train_busy && (train_count == 8'h00);
   wire [NUM_EVENTS-1:0] events = {train_done, level_capture, avg_done, drift_rise};
   wire [NUM_EVENTS-1:0] irq_clear = (wr_i && hit_irq) ? wdata_i[NUM_EVENTS-1:0] : '0;

   // R02 initial averaging
   period_average u_average (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(cal_trigger),
      .depth_i(initial_average_depth),
      .sample_valid_i(meas_valid_i && (cal_state == CAL_INIT)),
      .sample_i(meas_period_i),
      .done_o(avg_done),
      .mean_o(avg_mean)
   );

   // R01 drift detection
   drift_monitor u_drift (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .current_i(filt_period),
      .reference_i(ref_period),
      .limit_i(drift_limit),
      .drift_o(drift_now)
   );

   // Software writes; reserved bits masked off
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // R12 second register reset
         phy_general_config_one <= CONFIG_ONE_RESET;
         phy_general_config_two <= CONFIG_TWO_RESET;
         irq_mask <= '0;
      end else begin
         // R16 reserved bits held
         if (wr_i && hit_one) begin
            phy_general_config_one <= wdata_i & CONFIG_ONE_MASK;
         end
         if (wr_i && hit_two) begin
            phy_general_config_two <= wdata_i & CONFIG_TWO_MASK;
         end
         if (wr_i && hit_mask) begin
            irq_mask <= wdata_i[NUM_EVENTS-1:0];
         end
      end
   end

   // Sticky events; a set in the clearing cycle wins
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_status <= '0;
         irq_o <= 1'b0;
         rdata_o <= '0;
         drift_prev <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | events;
         irq_o <= |(irq_status & irq_mask);
         // R08 reserved read as zero
         rdata_o <= next_rdata;
         drift_prev <= drift_now;
      end
   end

   // Calibration sequencing
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cal_state <= CAL_INIT;
         ref_period <= '0;
         filt_period <= '0;
      end else begin
         case (cal_state)
            CAL_INIT: begin
               if (avg_done) begin
                  ref_period <= avg_mean;
                  filt_period <= avg_mean;
                  cal_state <= master_delay_enable ? CAL_TRACK : CAL_HOLD;
               end
            end
            CAL_TRACK: begin
               // R05 continued tracking
               if (cal_trigger) begin
                  cal_state <= CAL_INIT;
               end else if (!master_delay_enable) begin
                  cal_state <= CAL_HOLD;
               end else if (meas_valid_i) begin
                  filt_period <= next_filt;
               end
            end
            CAL_HOLD: begin
               if (cal_trigger) begin
                  cal_state <= CAL_INIT;
               end else if (master_delay_enable) begin
                  cal_state <= CAL_TRACK;
               end
            end
            default: begin
               cal_state <= CAL_INIT;
            end
         endcase
      end
   end

   // DQ response pin synchroniser
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dq_meta <= '0;
         dq_sync <= '0;
      end else begin
         dq_meta <= dq_response_i;
         dq_sync <= dq_meta;
      end
   end

   // Write leveling; triggers while busy are dropped
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         level_state <= LV_IDLE;
         level_count <= '0;
         level_delay_o <= '0;
         dqs_pulse_o <= 1'b0;
         leveling_dq_status <= '0;
      end else begin
         dqs_pulse_o <= 1'b0;
         case (level_state)
            LV_IDLE: begin
               // R10 software step
               if (leveling_trigger && software_leveling) begin
                  level_state <= LV_PULSE;
               end
            end
            LV_PULSE: begin
               // R09 delay advance
               dqs_pulse_o <= 1'b1;
               level_delay_o <= level_delay_o + step_amount;
               level_count <= 4'(LEVEL_CAPTURE_CYCLES - 1);
               level_state <= LV_WAIT;
            end
            LV_WAIT: begin
               // R10 capture response
               if (level_count == 4'h0) begin
                  leveling_dq_status <= dq_sync;
                  level_state <= LV_IDLE;
               end else begin
                  level_count <= level_count - 4'h1;
               end
            end
            default: begin
               level_state <= LV_IDLE;
            end
         endcase
      end
   end

   // R13 training wait timer
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         train_busy <= 1'b0;
         train_count <= '0;
         train_wait_done_o <= 1'b0;
      end else begin
         train_wait_done_o <= train_done;
         if (train_edge_i && !train_busy) begin
            train_busy <= 1'b1;
            train_count <= training_wait_timer;
         end else if (train_done) begin
            train_busy <= 1'b0;
         end else if (train_busy) begin
            train_count <= train_count - 8'h01;
         end
      end
   end

   // Registered copies of the controls
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         calibrated_period_o <= '0;
         delay_drift_status_o <= 1'b0;
         level_setup_o <= SETUP_90;
         level_hold_o <= HALF_CYCLE_UNITS - SETUP_90;
         io_standard_o <= '0;
         lane_powerdown_o <= '0;
         address_driver_powerdown_o <= 1'b0;
         fixed_read_latency_o <= 1'b0;
         no_bubble_select_o <= 1'b0;
         refresh_period_o <= '0;
      end else begin
         calibrated_period_o <= filt_period;
         // R01 drift status
         delay_drift_status_o <= drift_now;
         // R07 margins
         level_setup_o <= next_setup;
         level_hold_o <= HALF_CYCLE_UNITS - next_setup;
         io_standard_o <= phy_general_config_one[IO_STANDARD_LSB +: 2];
         // R11 lane power-down
         lane_powerdown_o <= lane_disabled_i & {LANES{disabled_lane_powerdown}};
         // R15 address drivers off
         address_driver_powerdown_o <= phy_general_config_two[ADDR_POWERDOWN_BIT];
         // R14 fixed read latency
         fixed_read_latency_o <= phy_general_config_two[FIXED_LATENCY_BIT];
         no_bubble_select_o <= phy_general_config_two[NO_BUBBLE_BIT];
         refresh_period_o <= phy_general_config_two[REFRESH_LSB +: 18];
      end
   end
endmodule : phy_general_config
`default_nettype wire

/* bench/phy_general_config_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_general_config_chk
   import phy_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [LANES-1:0] lane_disabled_i,
   input wire logic dqs_pulse_o,
   input wire logic [9:0] level_delay_o,
   input wire logic [2:0] level_setup_o,
   input wire logic [2:0] level_hold_o,
   input wire logic [1:0] io_standard_o,
   input wire logic [LANES-1:0] lane_powerdown_o,
   input wire logic address_driver_powerdown_o,
   input wire logic fixed_read_latency_o,
   input wire logic [17:0] refresh_period_o,
   input wire logic train_wait_done_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Read decodes; outputs are copies taken on the same edge as read data
   wire logic rd_one = rd_i && addr_i == OFS_CONFIG_ONE;
   wire logic rd_two = rd_i && addr_i == OFS_CONFIG_TWO;

   // Register reads against the outputs they drive
   a_reserved_one_zero: assert property (rd_one |=> rdata_o[31:23] == 9'h0 && rdata_o[5:3] == 3'h0)
      else $error("reserved bits of config one read nonzero");
   a_margin_select: assert property (rd_one |=> level_setup_o == (rdata_o[6] ? 3'h3 : 3'h2)
      && level_hold_o == (rdata_o[6] ? 3'h1 : 3'h2))
      else $error("leveling margins do not follow select type");
   a_io_copy: assert property (rd_one |=> io_standard_o == rdata_o[8:7])
      else $error("io standard output differs from register");
   a_lane_powerdown: assert property (rd_one |=> lane_powerdown_o == ($past(lane_disabled_i) & {LANES{rdata_o[0]}}))
      else $error("lane power down wrong");
   a_two_copy: assert property (rd_two |=> refresh_period_o == rdata_o[17:0] && rdata_o[30:28] == 3'h0
      && fixed_read_latency_o == rdata_o[19] && address_driver_powerdown_o == rdata_o[31])
      else $error("config two outputs differ from register");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data not zero outside read");
   // Leveling pulses and delay steps; training wait done pulse
   a_step_amount: assert property (dqs_pulse_o |-> level_delay_o == $past(level_delay_o) + 10'h020
      || level_delay_o == $past(level_delay_o) + 10'h001)
      else $error("leveling step not 32 or 1");
   a_delay_only_step: assert property ($changed(level_delay_o) |-> dqs_pulse_o)
      else $error("leveling delay moved without pulse");
   a_dqs_single: assert property (dqs_pulse_o |=> !dqs_pulse_o)
      else $error("dqs pulse longer than one cycle");
   a_train_single: assert property (train_wait_done_o |=> !train_wait_done_o)
      else $error("training wait done longer than one cycle");
endmodule : phy_general_config_chk

bind phy_general_config phy_general_config_chk phy_general_config_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lane_disabled_i(lane_disabled_i), .dqs_pulse_o(dqs_pulse_o),
   .level_delay_o(level_delay_o), .level_setup_o(level_setup_o), .level_hold_o(level_hold_o),
   .io_standard_o(io_standard_o), .lane_powerdown_o(lane_powerdown_o),
   .address_driver_powerdown_o(address_driver_powerdown_o), .fixed_read_latency_o(fixed_read_latency_o),
   .refresh_period_o(refresh_period_o), .train_wait_done_o(train_wait_done_o));
`default_nettype wire

/* bench/phy_general_config_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_general_config_tb
   import phy_cfg_pkg::*;
;
   logic mclk_i = 1'b0;
   logic sys_rst_i, wr_i, rd_i, irq_o, meas_valid_i, train_edge_i, delay_drift_status_o, dqs_pulse_o;
   logic address_driver_powerdown_o, fixed_read_latency_o, no_bubble_select_o, train_wait_done_o;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o, rv;
   logic [PERIOD_W-1:0] meas_period_i, calibrated_period_o;
   logic [LANES-1:0] lane_disabled_i, dq_response_i, lane_powerdown_o;
   logic [9:0] level_delay_o;
   logic [2:0] level_setup_o, level_hold_o;
   logic [1:0] io_standard_o;
   logic [17:0] refresh_period_o;
   int err_total = 0;
   int checks = 0;

   phy_general_config phy_general_config_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .meas_valid_i(meas_valid_i),
      .meas_period_i(meas_period_i), .lane_disabled_i(lane_disabled_i), .dq_response_i(dq_response_i),
      .train_edge_i(train_edge_i), .calibrated_period_o(calibrated_period_o),
      .delay_drift_status_o(delay_drift_status_o), .dqs_pulse_o(dqs_pulse_o), .level_delay_o(level_delay_o),
      .level_setup_o(level_setup_o), .level_hold_o(level_hold_o), .io_standard_o(io_standard_o),
      .lane_powerdown_o(lane_powerdown_o), .address_driver_powerdown_o(address_driver_powerdown_o),
      .fixed_read_latency_o(fixed_read_latency_o), .no_bubble_select_o(no_bubble_select_o),
      .refresh_period_o(refresh_period_o), .train_wait_done_o(train_wait_done_o));

   // Free running clock
   always #20 mclk_i = ~mclk_i;

   // Bus cycles, one strobe cycle each
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : settle
   task automatic smp(input logic [PERIOD_W-1:0] v);
      @(posedge mclk_i);
      meas_valid_i <= 1'b1; meas_period_i <= v;
      @(posedge mclk_i);
      meas_valid_i <= 1'b0;
   endtask : smp

   task automatic t_reset;
      rd(OFS_CONFIG_ONE, rv);
      chk("config_one", 32'h0000_C403, rv);
      rd(OFS_CONFIG_TWO, rv);
      chk("config_two", 32'h00F1_2480, rv);
      chk("refresh", 32'h0001_2480, 32'(refresh_period_o));
      chk("lane_pd", 32'h5, 32'(lane_powerdown_o));
      rd(8'h18, rv);
      chk("unmapped", 32'h0, rv);
   endtask : t_reset

   // averaging with interrupt raise, mask and clear
   task automatic t_average;
      wr(OFS_IRQ_MASK, 32'h2);
      for (int i = 0; i < 8; i++) smp(PERIOD_W'(96 + i));
      settle(4);
      chk("avg", 32'd99, 32'(calibrated_period_o));
      chk("irq", 32'h1, 32'(irq_o));
      wr(OFS_IRQ_STATUS, 32'h2);
      settle(2);
      chk("irq_clr", 32'h0, 32'(irq_o));
   endtask : t_average

   task automatic t_reserved;
      wr(OFS_CONFIG_ONE, 32'hFFFF_FFFF);
      rd(OFS_CONFIG_ONE, rv);
      chk("one_mask", 32'h007F_FFC7, rv);
      chk("io_std", 32'h3, 32'(io_standard_o));
      wr(OFS_CONFIG_TWO, 32'hFFFF_FFFF);
      rd(OFS_CONFIG_TWO, rv);
      chk("two_mask", 32'h8FFF_FFFF, rv);
      chk("no_bubble", 32'h1, 32'(no_bubble_select_o));
      wr(OFS_CONFIG_ONE, 32'h0000_C402);
      settle(2);
      chk("lane_pd_off", 32'h0, 32'(lane_powerdown_o));
      wr(OFS_CONFIG_ONE, 32'h0000_C403);
      wr(OFS_CONFIG_TWO, 32'h00F1_2480);
      lane_disabled_i <= 4'hC;
      settle(2);
      chk("lane_pd_c", 32'hC, 32'(lane_powerdown_o));
   endtask : t_reserved

   // tracking, filter and drift limit boundary
   task automatic t_track;
      wr(OFS_CONFIG_ONE, 32'h0005_C603);
      smp(PERIOD_W'(121));
      settle(6);
      chk("lowpass", 32'd110, 32'(calibrated_period_o));
      chk("drift_at", 32'h1, 32'(delay_drift_status_o));
      wr(OFS_CONFIG_ONE, 32'h0000_4603);
      settle(4);
      chk("drift_zero", 32'h0, 32'(delay_drift_status_o));
      wr(OFS_CONFIG_ONE, 32'h0006_4603);
      settle(4);
      chk("drift_below", 32'h0, 32'(delay_drift_status_o));
      wr(OFS_CONFIG_ONE, 32'h0000_0203);
      wr(OFS_COMMAND, 32'h2);
      smp(PERIOD_W'(10));
      smp(PERIOD_W'(13));
      settle(6);
      chk("avg_two", 32'd11, 32'(calibrated_period_o));
      smp(PERIOD_W'(90));
      settle(6);
      chk("no_lowpass", 32'd90, 32'(calibrated_period_o));
      wr(OFS_CONFIG_ONE, 32'h0000_0003);
      smp(PERIOD_W'(50));
      settle(6);
      chk("hold", 32'd90, 32'(calibrated_period_o));
   endtask : t_track

   // One leveling trigger, expecting a pulse and a delay step, or neither when the step is zero
   task automatic lvl(input logic [9:0] step);
      logic [9:0] d0;
      logic seen;
      d0 = level_delay_o;
      seen = 1'b0;
      wr(OFS_COMMAND, 32'h1);
      repeat (12) begin
         @(posedge mclk_i);
         #1;
         if (dqs_pulse_o === 1'b1) seen = 1'b1;
      end
      chk("dqs_pulse", 32'(step != 10'h0), 32'(seen));
      chk("delay", 32'(d0 + step), 32'(level_delay_o));
   endtask : lvl

   task automatic t_level;
      wr(OFS_CONFIG_ONE, 32'h0000_00C3);
      settle(2);
      chk("io_ddr3", 32'h1, 32'(io_standard_o));
      chk("setup135", 32'h3, 32'(level_setup_o));
      chk("hold45", 32'h1, 32'(level_hold_o));
      lvl(10'h020);
      rd(OFS_STATUS, rv);
      chk("dq_status", 32'hA, (rv >> 4) & 32'hF);
      wr(OFS_CONFIG_ONE, 32'h0000_0007);
      lvl(10'h001);
      chk("setup90", 32'h2, 32'(level_setup_o));
      wr(OFS_CONFIG_ONE, 32'h0000_0005);
      lvl(10'h000);
   endtask : t_level

   task automatic twait(input int n);
      int k;
      int at;
      at = 0;
      @(posedge mclk_i);
      train_edge_i <= 1'b1;
      @(posedge mclk_i);
      train_edge_i <= 1'b0;
      for (k = 1; k <= 40; k++) begin
         @(posedge mclk_i);
         #1;
         if (train_wait_done_o === 1'b1 && at == 0) at = k;
      end
      chk("train_wait", 32'(n + 1), 32'(at));
   endtask : twait

   task automatic conclude;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      sys_rst_i = 1'b1; addr_i = 8'h00; wdata_i = 32'h0; wr_i = 1'b0; rd_i = 1'b0; train_edge_i = 1'b0;
      meas_valid_i = 1'b0; meas_period_i = '0; lane_disabled_i = 4'h5; dq_response_i = 4'hA;
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_average;
      t_reserved;
      t_track;
      t_level;
      twait(15);
      wr(OFS_CONFIG_TWO, 32'h0031_2480);
      twait(3);
      conclude;
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge mclk_i);
      err_total++;
      conclude;
   end
endmodule : phy_general_config_tb
`default_nettype wire
